// *** prs_host_model.sv ***
// Purpose: Host master model for the ramp table and status serial port
// Assumes: Serial clock idles low, 800 ns period, stands still outside frames
// Notes:   Tasks are called by the testbench through the instance
`timescale 1ns/100ps
module prs_host_model (
    input  wire logic sys_clk,
    input  wire logic so_pin,
    output logic      csel_n,
    output logic      sclk,
    output logic      sdi
);
    initial begin
        csel_n = 1'b1;
        sclk   = 1'b0;
        sdi    = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // ========================================================================
    // Frame control; settle time covers the select synchroniser
    task automatic sel(input logic lvl);
        tk(1);
        csel_n = lvl;
        sdi    = ~sdi;
        tk(8);
    endtask
    // Sampled late in the high phase: the output lags the falling edge
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sdi = tx[i];
            tk(4);
            sclk = 1'b1;
            tk(3);
            rx[i] = so_pin;
            tk(1);
            sclk = 1'b0;
        end
    endtask
endmodule

// *** prs_pkg.sv ***
// Purpose: Shared constants for the power ramp table and status serial port
// Assumes: Single system clock at 10 MHz, serial link sampled as plain inputs
// Notes:   Offsets, field positions and reset values live here
package prs_pkg;
    // ========================================================================
    // Header layout
    localparam int unsigned HDR_RW_BIT    = 7;
    localparam int unsigned HDR_BURST_BIT = 6;
    localparam logic [5:0]  ADDR_RAMP     = 6'h3e;
    localparam logic [5:0]  ADDR_FLUSH_TX = 6'h3b;
    // ========================================================================
    // Status byte layout
    localparam int unsigned ST_RDY_BIT    = 7;
    localparam int unsigned ST_STATE_LSB  = 4;
    localparam logic [2:0]  ST_IDLE       = 3'h0;
    localparam logic [2:0]  ST_UNDERRUN   = 3'h7;
    localparam logic [3:0]  FREE_SAT      = 4'hf;
    // ========================================================================
    // Table geometry and reset values
    localparam int unsigned RAMP_DEPTH    = 8;
    localparam logic [7:0]  RAMP_RESET    = 8'h00;
    // Status pin select codes
    localparam logic [1:0]  PIN_SEL_HIZ   = 2'h0;
    localparam logic [1:0]  PIN_SEL_UNDER = 2'h1;
    localparam logic [1:0]  PIN_SEL_READY = 2'h2;
    localparam logic [1:0]  PIN_SEL_LOW_FREE = 2'h3;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    typedef enum logic [1:0] {
        PRS_HDR  = 2'b00,
        PRS_DATA = 2'b01,
        PRS_SKIP = 2'b10
    } prs_phase_t;
endpackage

// *** prs_port.sv ***
// Purpose: Serial slave for ramp table access, status byte and status pins
// Assumes: Serial clock well below sys_clk/4; all link pins synchronised
// Notes:   Only the ramp table and the flush strobe header are decoded
`timescale 1ns/100ps
module prs_port #(
    parameter int unsigned DEPTH = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       csel_n,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe_n,
    input  wire logic       dedicated_status_pin_i,
    output logic            dedicated_status_pin_o,
    output logic            dedicated_status_pin_oe_n,
    input  wire logic       core_ready,
    input  wire logic [2:0] main_state,
    input  wire logic       underrun_event,
    input  wire logic [6:0] tx_free_bytes,
    input  wire logic       sleep_enter,
    input  wire logic       serial_tx_mode,
    input  wire logic [1:0] shared_pin_sel,
    input  wire logic [1:0] dedicated_pin_sel,
    input  wire logic [2:0] power_level_select,
    output logic [7:0]      pa_setting,
    output logic            flush_tx_strobe,
    output logic            serial_tx_data
);
    // ========================================================================
    // Synchronisers
    logic [2:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic       sclk_d_reg, sclk_d_next, din_sync_reg, din_sync_next;
    logic       din_meta_reg, din_meta_next;
    always_comb begin
        sync1_next    = {csel_n, sclk, sdi};
        sync2_next    = sync1_reg;
        sclk_d_next   = sync2_reg[1];
        din_meta_next = dedicated_status_pin_i;
        din_sync_next = din_meta_reg;
    end
    // Reset to idle pin levels: select high, clock low, so no false edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_reg    <= 3'h4;
            sync2_reg    <= 3'h4;
            sclk_d_reg   <= 1'b0;
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            sync1_reg    <= sync1_next;
            sync2_reg    <= sync2_next;
            sclk_d_reg   <= sclk_d_next;
            din_meta_reg <= din_meta_next;
            din_sync_reg <= din_sync_next;
        end
    end
    logic cs_hi, sck, si, rise, fall;
    assign cs_hi = sync2_reg[2];
    assign sck   = sync2_reg[1];
    assign si    = sync2_reg[0];
    assign rise  = sck & ~sclk_d_reg & ~cs_hi;
    assign fall  = ~sck & sclk_d_reg & ~cs_hi;

    // ========================================================================
    // Status byte and underrun latch
    logic under_reg, under_next;
    logic [3:0] free_sat;
    logic [2:0] state_code;
    logic [7:0] status_byte;
    assign free_sat = (tx_free_bytes > 7'(prs_pkg::FREE_SAT)) ?
                      prs_pkg::FREE_SAT : tx_free_bytes[3:0];
    // Underrun latch overrides main_state, which otherwise passes through unchanged
    assign state_code = under_reg ? prs_pkg::ST_UNDERRUN : main_state;
    assign status_byte = {~core_ready, state_code, free_sat};

    // ========================================================================
    // Serial engine
    prs_pkg::prs_phase_t phase_reg, phase_next;
    logic [2:0] bit_reg, bit_next, idx_reg, idx_next;
    logic [7:0] shin_reg, shin_next, shout_reg, shout_next;
    logic       burst_reg, burst_next, rd_reg, rd_next, flush_next;
    logic [7:0] ramp_reg [DEPTH], ramp_next [DEPTH];
    logic [7:0] rx_byte;
    logic       wr_en;
    assign rx_byte = {shin_reg[6:0], si};
    always_comb begin
        phase_next = phase_reg;
        bit_next   = bit_reg;
        idx_next   = idx_reg;
        shin_next  = shin_reg;
        shout_next = shout_reg;
        burst_next = burst_reg;
        rd_next    = rd_reg;
        flush_next = 1'b0;
        wr_en      = 1'b0;
        under_next = under_reg | underrun_event;
        if (cs_hi) begin
            phase_next = prs_pkg::PRS_HDR;
            bit_next   = 3'h0;
            idx_next   = 3'h0;
            shout_next = status_byte;
        end else if (rise) begin
            shin_next = rx_byte;
            bit_next  = bit_reg + 3'h1;
            if (bit_reg == prs_pkg::BIT_LAST) begin
                unique case (phase_reg)
                    prs_pkg::PRS_HDR: begin
                        rd_next    = rx_byte[prs_pkg::HDR_RW_BIT];
                        burst_next = rx_byte[prs_pkg::HDR_BURST_BIT];
                        if (rx_byte[5:0] == prs_pkg::ADDR_RAMP)
                            phase_next = prs_pkg::PRS_DATA;
                        else if (rx_byte[5:0] == prs_pkg::ADDR_FLUSH_TX &&
                                 !rx_byte[prs_pkg::HDR_RW_BIT] &&
                                 !rx_byte[prs_pkg::HDR_BURST_BIT]) begin
                            flush_next = 1'b1;
                            phase_next = prs_pkg::PRS_HDR;
                        end else
                            phase_next = prs_pkg::PRS_SKIP;
                    end
                    prs_pkg::PRS_DATA: begin
                        wr_en    = ~rd_reg;
                        idx_next = idx_reg + 3'h1;
                        // Single access hands back to header decode
                        if (!burst_reg)
                            phase_next = prs_pkg::PRS_HDR;
                    end
                    prs_pkg::PRS_SKIP: phase_next = prs_pkg::PRS_SKIP;
                    default:  phase_next = prs_pkg::PRS_SKIP;
                endcase
            end
        end else if (fall) begin
            // Reload at byte boundary: table byte on read, else status
            if (bit_reg == 3'h0) begin
                if (phase_reg == prs_pkg::PRS_DATA && rd_reg)
                    shout_next = ramp_reg[idx_reg];
                else
                    shout_next = status_byte;
            end else
                shout_next = {shout_reg[6:0], 1'b0};
        end
        if (flush_next)
            under_next = underrun_event;
        for (int i = 0; i < DEPTH; i++) begin
            ramp_next[i] = ramp_reg[i];
            if (sleep_enter)
                ramp_next[i] = prs_pkg::RAMP_RESET;
            else if (wr_en && idx_reg == i[2:0])
                ramp_next[i] = rx_byte;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_reg <= prs_pkg::PRS_HDR;
            bit_reg   <= 3'h0;
            idx_reg   <= 3'h0;
            shin_reg  <= 8'h00;
            shout_reg <= 8'h80;
            burst_reg <= 1'b0;
            rd_reg    <= 1'b0;
            under_reg <= 1'b0;
            flush_tx_strobe <= 1'b0;
            for (int i = 0; i < DEPTH; i++)
                ramp_reg[i] <= prs_pkg::RAMP_RESET;
        end else begin
            phase_reg <= phase_next;
            bit_reg   <= bit_next;
            idx_reg   <= idx_next;
            shin_reg  <= shin_next;
            shout_reg <= shout_next;
            burst_reg <= burst_next;
            rd_reg    <= rd_next;
            under_reg <= under_next;
            flush_tx_strobe <= flush_next;
            ramp_reg  <= ramp_next;
        end
    end
    assign pa_setting = ramp_reg[power_level_select];

    // ========================================================================
    // Status pins
    function automatic logic pin_val(input logic [1:0] sel, input logic u,
                                     input logic rdy, input logic [3:0] f);
        unique case (sel)
            prs_pkg::PIN_SEL_UNDER:    pin_val = u;
            prs_pkg::PIN_SEL_READY:    pin_val = ~rdy;
            prs_pkg::PIN_SEL_LOW_FREE: pin_val = (f == 4'h0);
            prs_pkg::PIN_SEL_HIZ:      pin_val = 1'b0;
        endcase
    endfunction
    logic sdo_reg, sdo_next, sdo_oe_n_reg, sdo_oe_n_next;
    logic ded_reg, ded_next, ded_oe_n_reg, ded_oe_n_next;
    always_comb begin
        if (!cs_hi) begin
            sdo_next      = shout_reg[7];
            sdo_oe_n_next = 1'b0;
        end else begin
            sdo_next      = pin_val(shared_pin_sel, under_reg, core_ready, free_sat);
            sdo_oe_n_next = (shared_pin_sel == prs_pkg::PIN_SEL_HIZ);
        end
        ded_next      = pin_val(dedicated_pin_sel, under_reg, core_ready, free_sat);
        ded_oe_n_next = serial_tx_mode;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sdo_reg      <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
            ded_reg      <= 1'b0;
            ded_oe_n_reg <= 1'b0;
        end else begin
            sdo_reg      <= sdo_next;
            sdo_oe_n_reg <= sdo_oe_n_next;
            ded_reg      <= ded_next;
            ded_oe_n_reg <= ded_oe_n_next;
        end
    end
    assign sdo = sdo_reg;
    assign sdo_oe_n = sdo_oe_n_reg;
    assign dedicated_status_pin_o = ded_reg;
    assign dedicated_status_pin_oe_n = ded_oe_n_reg;
    assign serial_tx_data = serial_tx_mode & din_sync_reg;

    // ========================================================================
    // Checks
    idx_cs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cs_hi |=> idx_reg == 3'h0) else $error("index not cleared");
    idx_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!cs_hi && rise && phase_reg == prs_pkg::PRS_DATA && bit_reg == 3'h7
         && idx_reg == 3'h7) |=> idx_reg == 3'h0) else $error("no wrap");
    single_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!cs_hi && rise && phase_reg == prs_pkg::PRS_DATA && bit_reg == 3'h7
         && !burst_reg) |=> phase_reg == prs_pkg::PRS_HDR) else $error("single");
    sleep_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sleep_enter |=> ramp_reg[0] == prs_pkg::RAMP_RESET) else $error("sleep");
    // Ready flag must be on the pin before the host's first clock edge
    rdy_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(cs_hi) |=> sdo == !$past(core_ready, 2)) else $error("ready bit");
    under_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (under_reg && !flush_next) |=> under_reg) else $error("underrun lost");
    free_sat_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_free_bytes >= 7'd15 |-> free_sat == 4'hf) else $error("sat");
    sdo_cs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !cs_hi |=> !sdo_oe_n && sdo == $past(shout_reg[7])) else $error("sdo");
    hiz_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cs_hi && shared_pin_sel == 2'h0) |=> sdo_oe_n) else $error("hiz");
    cancel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cs_hi |=> phase_reg == prs_pkg::PRS_HDR ##0 bit_reg == 3'h0)
        else $error("cancel");
    burst_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        burst_reg && phase_reg == prs_pkg::PRS_DATA && idx_reg == 3'h7);
    read_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rd_reg && phase_reg == prs_pkg::PRS_DATA && fall);
    flush_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        flush_tx_strobe && under_reg == 1'b0);
    wrap_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rise && rd_reg && phase_reg == prs_pkg::PRS_DATA && idx_reg == 3'h7);
    cancel_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(cs_hi) && bit_reg != 3'h0);

    // ========================================================================
    // Checks on the underrun latch, flush strobe, table writes, reloads and the dedicated pin direction
    // Set wins over a flush falling in the same cycle
    set_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        underrun_event |=> under_reg) else $error("underrun set lost");
    strobe_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        flush_tx_strobe |=> !flush_tx_strobe) else $error("strobe too long");
    wr_land_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_en && !sleep_enter) |=> ramp_reg[$past(idx_reg)] == $past(rx_byte))
        else $error("table write lost");
    rd_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fall && bit_reg == 3'h0 && phase_reg == prs_pkg::PRS_DATA && rd_reg)
        |=> shout_reg == $past(ramp_reg[idx_reg])) else $error("read load");
    hdr_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cs_hi |=> shout_reg == $past(status_byte)) else $error("status load");
    ded_dir_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> dedicated_status_pin_oe_n == $past(serial_tx_mode))
        else $error("pin direction");
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the ramp table and status serial port
// Assumes: 10 MHz system clock, host model acting as serial master
// Notes:   Random data from an 8-bit shift register seeded with 99
`timescale 1ns/100ps
module testbench;
    logic       sys_clk = 1'b0;
    logic       sys_rst, ded_i, core_ready, underrun_event, sleep_enter, serial_tx_mode;
    logic [2:0] main_state, power_level_select;
    logic [6:0] tx_free_bytes;
    logic [1:0] shared_pin_sel, dedicated_pin_sel;
    logic       csel_n, sclk, sdi, sdo, sdo_oe_n, ded_o, ded_oe_n, flush_tx_strobe, sd_tx;
    logic [7:0] pa_setting, rx, lfsr_q, ram [8];
    int         n_errors, compares, n_flush;
    // Released shared pin shows no stale level to the host
    wire logic  so_pin = sdo_oe_n ? ~sdo : sdo;
    always #50 sys_clk = ~sys_clk;
    // Counted mid-cycle, away from the edge that launches the strobe
    always @(negedge sys_clk) if (flush_tx_strobe === 1'b1) n_flush++;
    prs_port #(.DEPTH(8)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .csel_n(csel_n),
        .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .dedicated_status_pin_i(ded_i), .dedicated_status_pin_o(ded_o),
        .dedicated_status_pin_oe_n(ded_oe_n), .core_ready(core_ready),
        .main_state(main_state), .underrun_event(underrun_event),
        .tx_free_bytes(tx_free_bytes), .sleep_enter(sleep_enter),
        .serial_tx_mode(serial_tx_mode), .shared_pin_sel(shared_pin_sel),
        .dedicated_pin_sel(dedicated_pin_sel), .power_level_select(power_level_select),
        .pa_setting(pa_setting), .flush_tx_strobe(flush_tx_strobe), .serial_tx_data(sd_tx));
    prs_host_model i_host (.sys_clk(sys_clk), .so_pin(so_pin), .csel_n(csel_n),
        .sclk(sclk), .sdi(sdi));
    // ========================================================================
    // Helpers
    function automatic logic [7:0] lfsr();
        lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        return lfsr_q;
    endfunction
    function automatic logic [7:0] st_exp(input logic und);
        return {~core_ready, und ? prs_pkg::ST_UNDERRUN : main_state,
                (tx_free_bytes > 7'd15) ? prs_pkg::FREE_SAT : tx_free_bytes[3:0]};
    endfunction
    function automatic logic pin_exp(input logic [1:0] s, input logic und);
        case (s)
            2'h1:    return und;
            2'h2:    return ~core_ready;
            2'h3:    return tx_free_bytes == 7'h00;
            default: return 1'b0;
        endcase
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_tab();
        for (int i = 0; i < 8; i++) begin
            power_level_select = i[2:0];
            tk(1);
            check(pa_setting, ram[i]);
        end
    endtask
    task automatic chk_pins(input logic und);
        for (int s = 0; s < 4; s++) begin
            shared_pin_sel    = s[1:0];
            dedicated_pin_sel = s[1:0];
            tk(6);
            check(sdo_oe_n, s == 0);
            if (s != 0) check(sdo, pin_exp(s[1:0], und));
            check(ded_o, pin_exp(s[1:0], und));
        end
    endtask
    task automatic stop_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end
    // ========================================================================
    // Main sequence
    initial begin
        sys_rst            = 1'b1;
        lfsr_q             = 8'h63;
        n_errors           = 0;
        compares           = 0;
        n_flush            = 0;
        ded_i              = 1'b0;
        core_ready         = 1'b1;
        underrun_event     = 1'b0;
        sleep_enter        = 1'b0;
        serial_tx_mode     = 1'b0;
        main_state         = 3'h0;
        power_level_select = 3'h0;
        tx_free_bytes      = 7'h00;
        shared_pin_sel     = 2'h0;
        dedicated_pin_sel  = 2'h0;
        for (int i = 0; i < 8; i++) ram[i] = 8'h00;
        tk(16);
        sys_rst = 1'b0;
        tk(4);
        chk_tab();
        check(sdo_oe_n, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            rx = lfsr();
            main_state     = rx[6:4];
            serial_tx_mode = rx[0];
            ded_i          = rx[1];
            core_ready     = i != 5;
            rx = lfsr();
            tx_free_bytes  = (i == 0) ? 7'h0f : (i == 1) ? 7'h10 : rx[7:1];
            i_host.sel(1'b0);
            check(sdo_oe_n, 1'b0);
            check(ded_oe_n, serial_tx_mode);
            check(sd_tx, serial_tx_mode & ded_i);
            i_host.xfer(8'h30, 8, rx);
            check(rx, st_exp(1'b0));
            i_host.sel(1'b1);
        end
        core_ready     = 1'b1;
        serial_tx_mode = 1'b0;
        $display("test status done");
        i_host.sel(1'b0);
        i_host.xfer(8'h7e, 8, rx);
        for (int i = 0; i < 8; i++) begin
            ram[i] = lfsr();
            i_host.xfer(ram[i], 8, rx);
            check(rx, st_exp(1'b0));
        end
        i_host.sel(1'b1);
        chk_tab();
        i_host.sel(1'b0);
        i_host.xfer(8'hfe, 8, rx);
        for (int i = 0; i < 11; i++) begin
            i_host.xfer(8'h00, 8, rx);
            check(rx, ram[i % 8]);
        end
        i_host.sel(1'b1);
        $display("test burst done");
        i_host.sel(1'b0);
        for (int i = 0; i < 2; i++) begin
            ram[i] = lfsr();
            i_host.xfer(8'h3e, 8, rx);
            i_host.xfer(ram[i], 8, rx);
        end
        i_host.sel(1'b1);
        chk_tab();
        i_host.sel(1'b0);
        i_host.xfer(8'hbe, 8, rx);
        i_host.xfer(8'h00, 8, rx);
        check(rx, ram[0]);
        i_host.xfer(8'h7e, 8, rx);
        i_host.xfer(~ram[0], 5, rx);
        i_host.sel(1'b1);
        chk_tab();
        $display("test single done");
        main_state     = 3'h2;
        underrun_event = 1'b1;
        tk(1);
        underrun_event = 1'b0;
        tk(3);
        chk_pins(1'b1);
        i_host.sel(1'b0);
        i_host.xfer(8'h30, 8, rx);
        check(rx, st_exp(1'b1));
        // Flush header pulses flush_tx_strobe once and clears the underrun latch
        i_host.sel(1'b1);
        i_host.sel(1'b0);
        i_host.xfer(8'h3b, 8, rx);
        i_host.sel(1'b1);
        check(n_flush[7:0], 8'h01);
        tx_free_bytes = 7'h00;
        chk_pins(1'b0);
        i_host.sel(1'b0);
        i_host.xfer(8'h30, 8, rx);
        check(rx, st_exp(1'b0));
        i_host.sel(1'b1);
        serial_tx_mode = 1'b1;
        for (int b = 0; b < 2; b++) begin
            ded_i = b[0];
            tk(5);
            check(sd_tx, b[0]);
            check(ded_oe_n, 1'b1);
        end
        serial_tx_mode = 1'b0;
        $display("test pins done");
        sleep_enter = 1'b1;
        tk(1);
        sleep_enter = 1'b0;
        tk(2);
        for (int i = 0; i < 8; i++) ram[i] = 8'h00;
        chk_tab();
        $display("test sleep done");
        stop_test();
    end
endmodule
